// >>> pstc_power_state_ctrl.sv
// Main power state machine with timed rail sequencing and readback.
//
// What this block does
// - Six power states: no power, off, on, sleep, backup, program.
// - No power disables everything and clears all registers.
// - Off keeps the clock running, holds registers, drives reset pin low.
// - Off disables rails except internal and optional always-on regulator.
// - On makes every function available.
// - Sleep entry and exit run a programmable rail sequence.
// - Backup disables every converter and regulator except the internal regulator.
// - Backup keeps clock, oscillator, scratch; resets everything else.
// - Backup may freeze the clock count to save power.
// - Core supply below power-on threshold forces no power.
// - Core supply below device-reset threshold forces backup.
// - Off, on and sleep moves run as timed configured sequences.
// - Off event in sleep goes straight to off, rails dropped at once.
// - Five-bit state field: off 00, program 0b, sleep 1c, on 1f.
// - Flag each completed move into backup, sleep, on or off.
// - Power button starts power-up and shutdown.
// - Five slots of 2 ms each, extended until slot rails are up.
// - On sequence over 2 s flags failure, forces off, drops rails.
// - System-on write 0 commands off; write 1 does nothing.
// - Sleep flag write 1 commands sleep, write 0 commands wake.
`timescale 1ns/1ns
`default_nettype none
module pstc_power_state_ctrl
  import pstc_pkg::*;
#(
  parameter int unsigned SLOT_CYC     = PSTC_SLOT_CYC,
  parameter int unsigned FAIL_CYC     = PSTC_FAIL_CYC,
  parameter int unsigned DLY_UNIT_CYC = PSTC_DLY_UNIT_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_core_above_por,
  input  wire logic        i_core_above_devrst,
  input  wire logic        i_pwr_button_n,
  input  wire logic [4:0]  i_slot_good,
  input  wire logic        i_prog_enter,
  input  wire logic        i_prog_exit,
  input  wire logic        i_rtc_unclocked_sel,
  input  wire logic        i_aon_keep_in_off,
  input  wire logic        i_reg_wr,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic      [4:0]  o_rail_en,
  output logic             o_int_reg_en,
  output logic             o_aon_reg_en,
  output logic             o_reset_out_n,
  output logic             o_rtc_run,
  output logic             o_rtc_count_en,
  output logic             o_scratch_keep,
  output logic             o_func_rst,
  output logic             o_seq_fail,
  output pstc_trans_s      o_trans_done,
  output logic      [4:0]  o_state_code
);
  initial begin
    if (FAIL_CYC <= SLOT_CYC) $error("FAIL_CYC must exceed SLOT_CYC");
    if (DLY_UNIT_CYC < 1) $error("DLY_UNIT_CYC must be at least 1");
  end

  pstc_state_e state_q, prev_q;
  pstc_kind_e  kind_q;
  logic [31:0] dly_cnt_q, fail_cnt_q, dly_cyc;
  logic [1:0]  dly_q;
  logic [4:0]  on_en_q, slp_en_q, good_s;
  logic        por_s, devrst_s, btn_s, btn_prev_q, btn_fall;
  logic        seq_start_q, seq_busy, seq_slot_start, seq_done, slot_ok;
  logic [2:0]  seq_slot, rev_slot;
  logic        wr_ps, host_off, host_slp, host_wake;
  logic        off_evt, fail, go_dead, imm_off, sys_on;

  // Pins from outside the core clock domain
  pstc_sync #(.W(8)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_core_above_por, i_core_above_devrst,
                  i_pwr_button_n, i_slot_good}),
    .o_sync     ({por_s, devrst_s, btn_s, good_s})
  );

  // Button press is a falling edge of the synchronised level
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      btn_prev_q <= 1'b0;
    end else begin
      btn_prev_q <= btn_s;
    end
  end
  assign btn_fall = btn_prev_q & ~btn_s;

  // Host commands decoded from power-state register writes
  assign wr_ps     = i_reg_wr && (i_reg_addr == PSTC_ADDR_POWER_STATE);
  assign host_off  = wr_ps && !i_reg_wdata[PSTC_SYS_ON_BIT];
  assign host_slp  = wr_ps && i_reg_wdata[PSTC_SYS_ON_BIT] &&
                     i_reg_wdata[PSTC_SLEEP_BIT];
  assign host_wake = wr_ps && i_reg_wdata[PSTC_SYS_ON_BIT] &&
                     !i_reg_wdata[PSTC_SLEEP_BIT];
  assign off_evt   = btn_fall || host_off;
  assign go_dead   = !por_s || !devrst_s;
  assign fail      = (state_q == ST_ON_SEQ) &&
                     (fail_cnt_q == FAIL_CYC - 1);
  assign imm_off   = fail || (state_q == ST_SLEEP && off_evt);
  assign dly_cyc   = 32'(dly_q) * 32'(DLY_UNIT_CYC);

  function automatic pstc_state_e seq_state(input pstc_kind_e k);
    case (k)
      SK_ON:   seq_state = ST_ON_SEQ;
      SK_OFF:  seq_state = ST_OFF_SEQ;
      SK_SLP:  seq_state = ST_SLP_SEQ;
      default: seq_state = ST_WK_SEQ;
    endcase
  endfunction

  // Main state machine; supply monitors override everything
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= ST_NOPWR;
      kind_q      <= SK_ON;
      dly_cnt_q   <= 32'h0;
      seq_start_q <= 1'b0;
    end else begin
      seq_start_q <= 1'b0;
      if (!por_s) begin
        state_q <= ST_NOPWR;
      end else if (!devrst_s) begin
        state_q <= ST_BACKUP;
      end else begin
        case (state_q)
          ST_NOPWR, ST_BACKUP: state_q <= ST_OFF;
          ST_OFF: begin
            if (i_prog_enter) begin
              state_q <= ST_PROG;
            end else if (btn_fall) begin
              state_q     <= ST_ON_SEQ;
              kind_q      <= SK_ON;
              seq_start_q <= 1'b1;
            end
          end
          ST_PROG: if (i_prog_exit) state_q <= ST_OFF;
          ST_ON: begin
            if (off_evt) begin
              state_q   <= ST_DLY;
              kind_q    <= SK_OFF;
              dly_cnt_q <= dly_cyc;
            end else if (host_slp) begin
              state_q   <= ST_DLY;
              kind_q    <= SK_SLP;
              dly_cnt_q <= dly_cyc;
            end
          end
          ST_SLEEP: begin
            if (off_evt) begin
              state_q <= ST_OFF;
            end else if (host_wake) begin
              state_q   <= ST_DLY;
              kind_q    <= SK_WAKE;
              dly_cnt_q <= dly_cyc;
            end
          end
          ST_DLY: begin
            if (dly_cnt_q == 32'h0) begin
              state_q     <= seq_state(kind_q);
              seq_start_q <= 1'b1;
            end else begin
              dly_cnt_q <= dly_cnt_q - 32'h1;
            end
          end
          ST_ON_SEQ: begin
            if (fail) state_q <= ST_OFF;
            else if (seq_done) state_q <= ST_ON;
          end
          ST_OFF_SEQ: if (seq_done) state_q <= ST_OFF;
          ST_SLP_SEQ: if (seq_done) state_q <= ST_SLEEP;
          ST_WK_SEQ:  if (seq_done) state_q <= ST_ON;
          default:    state_q <= ST_NOPWR;
        endcase
      end
    end
  end

  // Slot order is reversed for the off and wake sequences
  assign rev_slot = 3'(PSTC_NUM_SLOTS - 1) - seq_slot;
  always_comb begin
    case (kind_q)
      SK_ON:   slot_ok = good_s[seq_slot];
      SK_WAKE: slot_ok = good_s[rev_slot];
      default: slot_ok = 1'b1;
    endcase
  end

  pstc_slot_seq #(.SLOT_CYC(SLOT_CYC)) u_seq (
    .i_core_clk   (i_core_clk),
    .i_rst_n      (i_rst_n),
    .i_start      (seq_start_q),
    .i_abort      (fail || go_dead),
    .i_slot_ok    (slot_ok),
    .o_busy       (seq_busy),
    .o_slot       (seq_slot),
    .o_slot_start (seq_slot_start),
    .o_done       (seq_done)
  );

  // Rail enables: on group follows on/off, sleep group follows sleep/wake
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_en_q  <= 5'h00;
      slp_en_q <= 5'h1f;
    end else if (go_dead || imm_off || state_q == ST_OFF) begin
      on_en_q  <= 5'h00;
      slp_en_q <= 5'h1f;
    end else if (seq_slot_start) begin
      case (kind_q)
        SK_ON:   on_en_q[seq_slot]  <= 1'b1;
        SK_OFF:  on_en_q[rev_slot]  <= 1'b0;
        SK_SLP:  slp_en_q[seq_slot] <= 1'b0;
        default: slp_en_q[rev_slot] <= 1'b1;
      endcase
    end
  end
  assign o_rail_en = on_en_q & slp_en_q;

  // Failure watchdog over the whole on sequence
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fail_cnt_q <= 32'h0;
      o_seq_fail <= 1'b0;
    end else begin
      o_seq_fail <= fail;
      if (state_q == ST_ON_SEQ && !fail) fail_cnt_q <= fail_cnt_q + 32'h1;
      else fail_cnt_q <= 32'h0;
    end
  end

  // Delay field; lost in no power and backup, kept in off
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dly_q <= PSTC_DLY_RESET;
    end else if (go_dead) begin
      dly_q <= PSTC_DLY_RESET;
    end else if (wr_ps) begin
      dly_q <= i_reg_wdata[PSTC_DLY_LSB +: 2];
    end
  end

  // State code; sequences show transitional values until done
  always_comb begin
    case (state_q)
      ST_OFF:     o_state_code = PSTC_CODE_OFF;
      ST_PROG:    o_state_code = PSTC_CODE_PROG;
      ST_SLEEP:   o_state_code = PSTC_CODE_SLEEP;
      ST_ON:      o_state_code = PSTC_CODE_ON;
      ST_BACKUP:  o_state_code = PSTC_CODE_BACKUP;
      ST_ON_SEQ:  o_state_code = PSTC_CODE_ON_SEQ;
      ST_OFF_SEQ: o_state_code = PSTC_CODE_OFF_SEQ;
      ST_SLP_SEQ: o_state_code = PSTC_CODE_SLP_SEQ;
      ST_WK_SEQ:  o_state_code = PSTC_CODE_WK_SEQ;
      ST_DLY:     o_state_code = PSTC_CODE_DLY;
      default:    o_state_code = PSTC_CODE_NOPWR;
    endcase
  end

  assign sys_on = (state_q == ST_ON) || (state_q == ST_SLEEP) ||
                  (state_q == ST_DLY) || (state_q == ST_OFF_SEQ) ||
                  (state_q == ST_SLP_SEQ) || (state_q == ST_WK_SEQ);

  // Register read data, one cycle after the address
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= PSTC_READBACK_RESET;
    end else begin
      case (i_reg_addr)
        PSTC_ADDR_READBACK:
          o_reg_rdata <= {11'h000, o_state_code};
        PSTC_ADDR_POWER_STATE:
          o_reg_rdata <= {sys_on, state_q == ST_SLEEP, 2'h0, dly_q, 10'h000};
        default:
          o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Completion flags pulse the cycle after a stable state is entered
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q       <= ST_NOPWR;
      o_trans_done <= '0;
    end else begin
      prev_q              <= state_q;
      o_trans_done.backup <= state_q == ST_BACKUP && prev_q != ST_BACKUP;
      o_trans_done.sleep  <= state_q == ST_SLEEP && prev_q != ST_SLEEP;
      o_trans_done.on     <= state_q == ST_ON && prev_q != ST_ON;
      o_trans_done.off    <= state_q == ST_OFF && prev_q != ST_OFF;
    end
  end

  // Supply and pin controls follow the state; reset pin low when off
  assign o_reset_out_n  = sys_on || state_q == ST_ON_SEQ;
  assign o_int_reg_en   = state_q != ST_NOPWR;
  assign o_aon_reg_en   = sys_on || state_q == ST_ON_SEQ ||
                          (state_q == ST_OFF && i_aon_keep_in_off);
  assign o_rtc_run      = state_q != ST_NOPWR;
  assign o_rtc_count_en = state_q != ST_NOPWR &&
                          !(state_q == ST_BACKUP && i_rtc_unclocked_sel);
  assign o_scratch_keep = state_q != ST_NOPWR;
  assign o_func_rst     = state_q == ST_NOPWR || state_q == ST_BACKUP;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_nopwr;
    !por_s |=> state_q == ST_NOPWR && o_func_rst;
  endproperty
  a_nopwr: assert property (p_nopwr)
    else $error("low core supply did not force no power");

  property p_backup;
    por_s && !devrst_s |=> state_q == ST_BACKUP ##0 o_rail_en == 5'h00;
  endproperty
  a_backup: assert property (p_backup)
    else $error("backup entry or rail shutdown missing");

  property p_off_pins;
    state_q == ST_OFF |-> !o_reset_out_n && o_rail_en == 5'h00;
  endproperty
  a_off_pins: assert property (p_off_pins)
    else $error("off state with reset high or rails on");

  property p_sleep_off;
    state_q == ST_SLEEP && off_evt && !go_dead |=>
      state_q == ST_OFF && o_rail_en == 5'h00;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("sleep to off was not immediate");

  property p_on_write_one;
    state_q == ST_ON && host_wake && !btn_fall && !go_dead |=>
      state_q == ST_ON;
  endproperty
  a_on_write_one: assert property (p_on_write_one)
    else $error("writing system-on one started a transition");

  property p_sleep_cmd;
    state_q == ST_ON && host_slp && !btn_fall && !go_dead |=>
      state_q == ST_DLY && kind_q == SK_SLP;
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd)
    else $error("sleep command not taken");

  property p_fail;
    fail && !go_dead |=> state_q == ST_OFF && o_seq_fail &&
      o_rail_en == 5'h00;
  endproperty
  a_fail: assert property (p_fail)
    else $error("sequence failure did not force off");

  property p_on_flag;
    state_q == ST_ON && prev_q != ST_ON |=> o_trans_done.on;
  endproperty
  a_on_flag: assert property (p_on_flag)
    else $error("on completion flag missing");

  property p_readback;
    i_reg_addr == PSTC_ADDR_READBACK |=>
      o_reg_rdata == {11'h000, $past(o_state_code)};
  endproperty
  a_readback: assert property (p_readback)
    else $error("state readback wrong");

  property p_btn_on;
    state_q == ST_OFF && btn_fall && !i_prog_enter && !go_dead |=>
      state_q == ST_ON_SEQ ##1 seq_busy;
  endproperty
  a_btn_on: assert property (p_btn_on)
    else $error("button did not start power-up");

  c_on_done:  cover property (state_q == ST_ON_SEQ ##1 state_q == ST_ON);
  c_sleep:    cover property (state_q == ST_SLP_SEQ ##1 state_q == ST_SLEEP);
  c_fail:     cover property (o_seq_fail);
  c_backup:   cover property (o_trans_done.backup);
endmodule
`default_nettype wire

// >>> pstc_pkg.sv
// Shared constants and types for the power state controller.
package pstc_pkg;

  // Core clock and sequence timing
  localparam int unsigned PSTC_CLK_MHZ          = 50;
  localparam int unsigned PSTC_SLOT_TIME_US     = 2000;
  localparam int unsigned PSTC_SLOT_CYC         =
    PSTC_SLOT_TIME_US * PSTC_CLK_MHZ;
  localparam int unsigned PSTC_FAIL_TIME_MS     = 2000;
  localparam int unsigned PSTC_FAIL_CYC         =
    PSTC_FAIL_TIME_MS * 1000 * PSTC_CLK_MHZ;
  localparam int unsigned PSTC_DLY_UNIT_TIME_US = 1000;
  localparam int unsigned PSTC_DLY_UNIT_CYC     =
    PSTC_DLY_UNIT_TIME_US * PSTC_CLK_MHZ;
  localparam int unsigned PSTC_NUM_SLOTS        = 5;

  // Register offsets
  localparam logic [15:0] PSTC_ADDR_POWER_STATE = 16'h4003;
  localparam logic [15:0] PSTC_ADDR_READBACK    = 16'h400d;

  // Field positions and reset values
  localparam int unsigned PSTC_SYS_ON_BIT       = 15;
  localparam int unsigned PSTC_SLEEP_BIT        = 14;
  localparam int unsigned PSTC_DLY_LSB          = 10;
  localparam logic [1:0]  PSTC_DLY_RESET        = 2'h2;
  localparam logic [15:0] PSTC_READBACK_RESET   = 16'h0000;

  // State readback codes, stable then transitional
  localparam logic [4:0] PSTC_CODE_OFF     = 5'h00;
  localparam logic [4:0] PSTC_CODE_PROG    = 5'h0b;
  localparam logic [4:0] PSTC_CODE_SLEEP   = 5'h1c;
  localparam logic [4:0] PSTC_CODE_ON      = 5'h1f;
  localparam logic [4:0] PSTC_CODE_BACKUP  = 5'h01;
  localparam logic [4:0] PSTC_CODE_NOPWR   = 5'h02;
  localparam logic [4:0] PSTC_CODE_ON_SEQ  = 5'h11;
  localparam logic [4:0] PSTC_CODE_OFF_SEQ = 5'h12;
  localparam logic [4:0] PSTC_CODE_SLP_SEQ = 5'h13;
  localparam logic [4:0] PSTC_CODE_WK_SEQ  = 5'h14;
  localparam logic [4:0] PSTC_CODE_DLY     = 5'h15;

  typedef enum logic [3:0] {
    ST_NOPWR, ST_BACKUP, ST_OFF, ST_PROG, ST_ON_SEQ, ST_ON, ST_DLY,
    ST_OFF_SEQ, ST_SLP_SEQ, ST_SLEEP, ST_WK_SEQ
  } pstc_state_e;

  typedef enum logic [1:0] {
    SK_ON, SK_OFF, SK_SLP, SK_WAKE
  } pstc_kind_e;

  // One-cycle completion pulses per target state
  typedef struct packed {
    logic backup;
    logic sleep;
    logic on;
    logic off;
  } pstc_trans_s;

endpackage

// >>> pstc_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ns
`default_nettype none
module pstc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> pstc_slot_seq.sv
// Five-slot timed sequencer with slot extension on power-good.
`timescale 1ns/1ns
`default_nettype none
module pstc_slot_seq
  import pstc_pkg::*;
#(
  parameter int unsigned SLOT_CYC = PSTC_SLOT_CYC
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic       i_abort,
  input  wire logic       i_slot_ok,
  output logic            o_busy,
  output logic [2:0]      o_slot,
  output logic            o_slot_start,
  output logic            o_done
);
  initial begin
    if (SLOT_CYC < 2) $error("SLOT_CYC must be at least 2");
  end

  logic [31:0] cnt_q;
  logic        slot_end;

  // A slot ends after its nominal time and once its rails are up
  assign slot_end = o_busy && (cnt_q >= SLOT_CYC - 1) && i_slot_ok;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy       <= 1'b0;
      o_slot       <= 3'h0;
      cnt_q        <= 32'h0;
      o_slot_start <= 1'b0;
      o_done       <= 1'b0;
    end else begin
      o_slot_start <= 1'b0;
      o_done       <= 1'b0;
      if (i_abort) begin
        o_busy <= 1'b0;
      end else if (i_start) begin
        o_busy       <= 1'b1;
        o_slot       <= 3'h0;
        cnt_q        <= 32'h0;
        o_slot_start <= 1'b1;
      end else if (slot_end) begin
        cnt_q <= 32'h0;
        if (o_slot == 3'(PSTC_NUM_SLOTS - 1)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          o_slot       <= o_slot + 3'h1;
          o_slot_start <= 1'b1;
        end
      end else if (o_busy && cnt_q < SLOT_CYC - 1) begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_slot_min;
    o_slot_start && !i_abort |=> !o_done && !o_slot_start;
  endproperty
  a_slot_min: assert property (p_slot_min)
    else $error("slot ended one cycle after it began");

  property p_wait_good;
    o_busy && !i_slot_ok && !i_abort && !i_start |=> !o_done;
  endproperty
  a_wait_good: assert property (p_wait_good)
    else $error("slot ended while its rails were not up");
endmodule
`default_nettype wire

// >>> pstc_host_model.sv
// Host model: register writes, register reads, program-state pulses.
`timescale 1ns/1ns
`default_nettype none
module pstc_host_model (
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_reg_rdata,
  output logic             o_reg_wr,
  output logic [15:0]      o_reg_addr,
  output logic [15:0]      o_reg_wdata,
  output logic             o_prog_enter,
  output logic             o_prog_exit
);
  // Idle bus at time zero
  initial begin
    o_reg_wr     = 1'b0;
    o_reg_addr   = 16'h0000;
    o_reg_wdata  = 16'h0000;
    o_prog_enter = 1'b0;
    o_prog_exit  = 1'b0;
  end

  // Strobe for one cycle; data is scrambled once the taking edge has passed
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b1;
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b0;
    o_reg_wdata <= ~d;
  endtask

  // Read data lags the address by one cycle
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    @(posedge i_core_clk);
    #1;
    d = i_reg_rdata;
  endtask

  // Program state is entered only through its own pulse; left through the exit pulse or a supply drop
  task automatic prog(input logic enter);
    @(posedge i_core_clk);
    o_prog_enter <= enter;
    o_prog_exit  <= !enter;
    @(posedge i_core_clk);
    o_prog_enter <= 1'b0;
    o_prog_exit  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> power_state_controller_bench.sv
// Self-checking bench for the power state controller.
`timescale 1ns/1ns
`default_nettype none
module power_state_controller_bench
  import pstc_pkg::*;
;
  localparam int unsigned SLOT  = 4;
  localparam int unsigned FAIL  = 200;
  localparam int unsigned DUNIT = 3;
  localparam logic [15:0] PS    = PSTC_ADDR_POWER_STATE;
  logic clk = 1'b0, rst_n = 1'b0, por = 1'b1, devrst = 1'b1;
  logic btn_n = 1'b1, rtc_sel = 1'b0, aon_keep = 1'b1;
  logic [4:0] slot_good = 5'h1f;
  logic reg_wr, prog_enter, prog_exit;
  logic [15:0] reg_addr, reg_wdata, rdata, rv;
  logic [15:0] rnd = 16'h0020;
  logic [4:0] rail, code;
  logic int_en, aon_en, rst_out_n, rtc_run, rtc_cnt, scratch, func_rst;
  logic seq_fail, fail_seen = 1'b0;
  pstc_trans_s trans, seen = '0;
  int err_total = 0;
  int n_compared = 0;
  int k;

  always #10 clk = ~clk;

  pstc_power_state_ctrl #(.SLOT_CYC(SLOT), .FAIL_CYC(FAIL),
    .DLY_UNIT_CYC(DUNIT)) i_pstc_power_state_ctrl (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_core_above_por(por),
    .i_core_above_devrst(devrst), .i_pwr_button_n(btn_n),
    .i_slot_good(slot_good), .i_prog_enter(prog_enter),
    .i_prog_exit(prog_exit), .i_rtc_unclocked_sel(rtc_sel),
    .i_aon_keep_in_off(aon_keep), .i_reg_wr(reg_wr),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
    .o_rail_en(rail), .o_int_reg_en(int_en), .o_aon_reg_en(aon_en),
    .o_reset_out_n(rst_out_n), .o_rtc_run(rtc_run),
    .o_rtc_count_en(rtc_cnt), .o_scratch_keep(scratch),
    .o_func_rst(func_rst), .o_seq_fail(seq_fail),
    .o_trans_done(trans), .o_state_code(code));

  pstc_host_model i_pstc_host_model (
    .i_core_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(reg_wr),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .o_prog_enter(prog_enter), .o_prog_exit(prog_exit));

  // Sticky copies of one-cycle pulses; cleared off the edge by the tests
  always @(posedge clk) begin
    seen      <= seen | trans;
    fail_seen <= fail_seen | seq_fail;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Shortest sleep entry: delay (zero still costs a cycle) plus five slots
  function automatic int min_sleep(input logic [1:0] d);
    return ((d == 2'h0) ? 1 : d * DUNIT) + PSTC_NUM_SLOTS * SLOT;
  endfunction

  function automatic logic [15:0] cmd(input logic on, slp,
                                      input logic [1:0] d);
    return {on, slp, 2'h0, d, 10'h000};
  endfunction

  task automatic chk_val(input logic [15:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_code(input logic [4:0] got, exp, input string m);
    chk_val({11'h000, got}, {11'h000, exp}, m);
  endtask

  // Host trusts only the stable codes; the wait is bounded
  task automatic wait_code(input logic [4:0] c, input int n);
    k = 0;
    #1;
    while (code !== c && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk_code(code, c, "state");
    // Done pulses lag the state by one edge and the sticky copy by one more
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Hold the button long enough to pass the input synchroniser
  task automatic press;
    @(negedge clk);
    seen = '0;
    fail_seen = 1'b0;
    @(posedge clk);
    btn_n <= 1'b0;
    repeat (6) @(posedge clk);
    btn_n <= 1'b1;
    #1;
  endtask

  task automatic to_on;
    press;
    chk_code(code, PSTC_CODE_ON_SEQ, "on seq");
    wait_code(PSTC_CODE_ON, 100);
    chk_val({11'h0, rail}, 16'h001f, "rails on");
    chk_val({15'h0, seen.on}, 16'h1, "on flag");
    chk_val({15'h0, rst_out_n}, 16'h1, "reset pin");
  endtask

  task automatic to_sleep;
    // Step past the register's sparse start so the delay field varies
    repeat (8) rnd = lfsr_next(rnd);
    seen = '0;
    i_pstc_host_model.wr(PS, cmd(1'b1, 1'b1, rnd[1:0]));
    #1 chk_code(code, PSTC_CODE_DLY, "delay");
    wait_code(PSTC_CODE_SLEEP, 100);
    chk_val({15'h0, k >= min_sleep(rnd[1:0])}, 16'h1, "slp time");
    chk_val({11'h0, rail}, 16'h0000, "rails sleep");
    chk_val({15'h0, seen.sleep}, 16'h1, "sleep flag");
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run;
  end

  initial begin
    repeat (8) @(posedge clk);
    #1 chk_code(code, PSTC_CODE_NOPWR, "in reset");
    chk_val(rdata, PSTC_READBACK_RESET, "rdata reset");
    @(posedge clk) rst_n <= 1'b1;
    wait_code(PSTC_CODE_OFF, 10);
    chk_val({11'h0, rail}, 16'h0000, "rails off");
    chk_val({12'h0, int_en, aon_en, rst_out_n, rtc_run}, 16'h000d,
            "off outputs");
    $display("test off done");
    i_pstc_host_model.prog(1'b1);
    wait_code(PSTC_CODE_PROG, 4);
    i_pstc_host_model.prog(1'b0);
    wait_code(PSTC_CODE_OFF, 4);
    $display("test program done");
    to_on;
    i_pstc_host_model.rd(PSTC_ADDR_READBACK, rv);
    chk_val(rv, {11'h0, PSTC_CODE_ON}, "readback");
    i_pstc_host_model.rd(16'h4001, rv);
    chk_val(rv, 16'h0000, "unmapped");
    i_pstc_host_model.wr(PS, cmd(1'b1, 1'b0, 2'h0));
    repeat (3) @(posedge clk);
    #1 chk_code(code, PSTC_CODE_ON, "on write");
    $display("test on done");
    to_sleep;
    i_pstc_host_model.wr(PS, cmd(1'b1, 1'b0, rnd[3:2]));
    wait_code(PSTC_CODE_ON, 100);
    chk_val({11'h0, rail}, 16'h001f, "rails wake");
    to_sleep;
    press;
    chk_code(code, PSTC_CODE_OFF, "sleep off");
    chk_val({11'h0, rail}, 16'h0000, "rails drop");
    chk_val({15'h0, seen.off}, 16'h1, "off flag");
    $display("test sleep done");
    to_on;
    i_pstc_host_model.wr(PS, cmd(1'b0, 1'b0, rnd[5:4]));
    #1 chk_code(code, PSTC_CODE_DLY, "off delay");
    wait_code(PSTC_CODE_OFF, 100);
    chk_val({15'h0, seen.off}, 16'h1, "off flag");
    @(posedge clk) aon_keep <= 1'b0;
    #1 chk_val({15'h0, aon_en}, 16'h0000, "aon off");
    $display("test write off done");
    @(posedge clk) slot_good <= 5'h1b;
    press;
    repeat (40) @(posedge clk);
    #1 chk_val({11'h0, rail}, 16'h0007, "slot held");
    wait_code(PSTC_CODE_OFF, FAIL + 20);
    chk_val({11'h0, rail}, 16'h0000, "fail rails");
    chk_val({15'h0, fail_seen}, 16'h1, "fail flag");
    @(posedge clk) slot_good <= 5'h1f;
    $display("test failure done");
    to_on;
    @(posedge clk) begin
      rtc_sel <= 1'b1;
      devrst  <= 1'b0;
    end
    wait_code(PSTC_CODE_BACKUP, 10);
    chk_val({11'h0, rail}, 16'h0000, "backup rails");
    chk_val({12'h0, rtc_run, rtc_cnt, scratch, func_rst}, 16'h000b,
            "backup keep");
    chk_val({15'h0, seen.backup}, 16'h1, "backup flag");
    @(posedge clk) por <= 1'b0;
    wait_code(PSTC_CODE_NOPWR, 10);
    @(posedge clk) begin
      por    <= 1'b1;
      devrst <= 1'b1;
    end
    wait_code(PSTC_CODE_OFF, 10);
    $display("test supply done");
    complete_run;
  end
endmodule
`default_nettype wire
